// file: analog_value_range_encoder.sv
// Encodes input samples into process words and decodes output process words into drive levels.
// Assumes samples and requests are synchronous to clk_in; one result per request, one cycle later.
`timescale 1ns/10ps
`default_nettype none

module analog_value_range_encoder #(
    parameter int unsigned CHANNELS = 2
) (
    // Clock and reset
    input  wire logic                                            clk_in,
    input  wire logic                                            reset_in,
    // Input channels
    input  wire analog_range_pkg::in_sample_t [CHANNELS-1:0]     samples_in,
    output analog_range_pkg::in_result_t [CHANNELS-1:0]          in_results_out,
    // Output channels
    input  wire analog_range_pkg::out_req_t [CHANNELS-1:0]       out_reqs_in,
    output analog_range_pkg::out_result_t [CHANNELS-1:0]         out_results_out,
    // Station diagnostic byte
    output logic [7:0]                                           diag_out
);
    if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
        $error("CHANNELS must be between 1 and 8");
    end

    analog_range_pkg::in_result_t [CHANNELS-1:0]  in_res_d;
    analog_range_pkg::in_result_t [CHANNELS-1:0]  in_res_q;
    analog_range_pkg::out_result_t [CHANNELS-1:0] out_res_d;
    analog_range_pkg::out_result_t [CHANNELS-1:0] out_res_q;
    logic [CHANNELS-1:0]                          wire_d;
    logic [CHANNELS-1:0]                          wire_q;
    logic [CHANNELS-1:0]                          uflow_d;
    logic [CHANNELS-1:0]                          uflow_q;
    logic [7:0]                                   diag_d;
    logic [7:0]                                   diag_q;

    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        analog_range_pkg::limits_t in_lim;
        analog_range_pkg::limits_t out_lim;
        analog_range_pkg::cls_t    in_cls;
        analog_range_pkg::cls_t    out_cls;
        analog_range_pkg::units_t  out_val;
        analog_range_pkg::dac_t    out_masked;

        always_comb begin
            unique case (samples_in[g].mode)
                analog_range_pkg::IN_LOOP: begin
                    in_lim = {analog_range_pkg::NOMINAL_HI, analog_range_pkg::LOOP_ZERO,
                              analog_range_pkg::OVER_HI, analog_range_pkg::UNDER_LO_LOOP};
                end
                analog_range_pkg::IN_TEMP: begin
                    in_lim = {analog_range_pkg::TEMP_RATED_HI, analog_range_pkg::TEMP_RATED_LO,
                              analog_range_pkg::TEMP_OVER_HI, analog_range_pkg::TEMP_UNDER_LO};
                end
                default: begin
                    in_lim = {analog_range_pkg::NOMINAL_HI, analog_range_pkg::NOMINAL_LO,
                              analog_range_pkg::OVER_HI, analog_range_pkg::UNDER_LO_BIP};
                end
            endcase
        end

        range_classifier u_in_cls (
            .value_in  (samples_in[g].value),
            .limits_in (in_lim),
            .cls_out   (in_cls)
        );

        // Flags keep their last state between samples so the diagnostic byte does not flicker.
        always_comb begin
            in_res_d[g].valid = samples_in[g].valid;
            in_res_d[g].cls   = in_res_q[g].cls;
            in_res_d[g].word  = in_res_q[g].word;
            wire_d[g]         = wire_q[g];
            uflow_d[g]        = uflow_q[g];
            if (samples_in[g].valid) begin
                in_res_d[g].cls = in_cls;
                wire_d[g]       = 1'b0;
                uflow_d[g]      = 1'b0;
                if (in_cls == analog_range_pkg::CLS_OVERFLOW) begin
                    in_res_d[g].word = analog_range_pkg::CODE_OVERFLOW;
                end else if (in_cls == analog_range_pkg::CLS_UNDERFLOW) begin
                    in_res_d[g].word = analog_range_pkg::CODE_UNDERFLOW;
                end else if (samples_in[g].mode == analog_range_pkg::IN_TEMP) begin
                    in_res_d[g].word = samples_in[g].value[15:0];
                end else begin
                    in_res_d[g].word = samples_in[g].value[15:0] & analog_range_pkg::IN_JUST_MASK;
                end
                if (samples_in[g].mode == analog_range_pkg::IN_LOOP) begin
                    if (samples_in[g].wire_check) begin
                        if (samples_in[g].value <= analog_range_pkg::LOOP_LOW_3MA6) begin
                            in_res_d[g].word = analog_range_pkg::CODE_UNDERFLOW;
                            in_res_d[g].cls  = analog_range_pkg::CLS_UNDERFLOW;
                            wire_d[g]        = 1'b1;
                        end
                    end else if (samples_in[g].value <= analog_range_pkg::LOOP_LOW_1MA1) begin
                        in_res_d[g].word = analog_range_pkg::CODE_UNDERFLOW;
                        uflow_d[g]       = 1'b1;
                    end
                end
            end
        end

        // Output side: a code outside its limits drives no output at all.
        always_comb begin
            out_val = {{2{out_reqs_in[g].word[15]}}, out_reqs_in[g].word};
            out_masked = out_val[16:0] & {1'b1, analog_range_pkg::OUT_JUST_MASK};
            if (out_reqs_in[g].mode == analog_range_pkg::OUT_LOOP) begin
                out_lim = {analog_range_pkg::NOMINAL_HI, analog_range_pkg::LOOP_ZERO,
                           analog_range_pkg::OVER_HI, analog_range_pkg::UNDER_LO_OUT};
            end else begin
                out_lim = {analog_range_pkg::NOMINAL_HI, analog_range_pkg::NOMINAL_LO,
                           analog_range_pkg::OVER_HI, analog_range_pkg::UNDER_LO_BIP};
            end
        end

        range_classifier u_out_cls (
            .value_in  (out_val),
            .limits_in (out_lim),
            .cls_out   (out_cls)
        );

        always_comb begin
            out_res_d[g].valid = out_reqs_in[g].valid;
            out_res_d[g].cls   = out_res_q[g].cls;
            out_res_d[g].level = out_res_q[g].level;
            if (out_reqs_in[g].valid) begin
                out_res_d[g].cls = out_cls;
                if (out_cls == analog_range_pkg::CLS_OVERFLOW || out_cls == analog_range_pkg::CLS_UNDERFLOW) begin
                    out_res_d[g].level = '0;
                end else if (out_reqs_in[g].mode == analog_range_pkg::OUT_LOOP) begin
                    out_res_d[g].level = out_masked + analog_range_pkg::OUT_LOOP_OFFS;
                end else begin
                    out_res_d[g].level = out_masked;
                end
            end
        end

        // Checks on the value paths of this channel.
        sequence s_sample(analog_range_pkg::in_mode_t m);
            samples_in[g].valid && samples_in[g].mode == m;
        endsequence

        property p_bip_overflow;
            @(posedge clk_in) disable iff (reset_in)
            s_sample(analog_range_pkg::IN_BIPOLAR) ##0 (samples_in[g].value > 18'sd32511)
            |=> in_res_q[g].word == 16'h7fff && in_res_q[g].cls == analog_range_pkg::CLS_OVERFLOW;
        endproperty
        a_bip_overflow: assert property (p_bip_overflow) else $error("bipolar overflow code wrong");

        property p_bip_pass;
            @(posedge clk_in) disable iff (reset_in)
            s_sample(analog_range_pkg::IN_BIPOLAR) ##0
            (samples_in[g].value <= 18'sd32511 && samples_in[g].value >= -18'sd32512)
            |=> in_res_q[g].word == ($past(samples_in[g].value[15:0]) & 16'hfff8)
                && in_res_q[g].word[15] == $past(samples_in[g].value[17]);
        endproperty
        a_bip_pass: assert property (p_bip_pass) else $error("bipolar word not justified");

        property p_loop_under;
            @(posedge clk_in) disable iff (reset_in)
            s_sample(analog_range_pkg::IN_LOOP) ##0 (samples_in[g].value < -18'sd4864)
            |=> in_res_q[g].word == 16'h8000;
        endproperty
        a_loop_under: assert property (p_loop_under) else $error("loop underflow code wrong");

        property p_loop_uflow_flag;
            @(posedge clk_in) disable iff (reset_in)
            s_sample(analog_range_pkg::IN_LOOP) ##0 (!samples_in[g].wire_check && samples_in[g].value <= -18'sd5012)
            |=> diag_out[6];
        endproperty
        a_loop_uflow_flag: assert property (p_loop_uflow_flag) else $error("underflow flag missing");

        property p_wire_break;
            @(posedge clk_in) disable iff (reset_in)
            s_sample(analog_range_pkg::IN_LOOP) ##0 (samples_in[g].wire_check && samples_in[g].value <= -18'sd692)
            |=> in_res_q[g].word == 16'h8000 && diag_out[4];
        endproperty
        a_wire_break: assert property (p_wire_break) else $error("wire break not reported");

        property p_temp_pass;
            @(posedge clk_in) disable iff (reset_in)
            s_sample(analog_range_pkg::IN_TEMP) ##0
            (samples_in[g].value <= 18'sd10000 && samples_in[g].value >= -18'sd2430)
            |=> in_res_q[g].word == $past(samples_in[g].value[15:0]);
        endproperty
        a_temp_pass: assert property (p_temp_pass) else $error("temperature word altered");

        property p_temp_sat;
            @(posedge clk_in) disable iff (reset_in)
            s_sample(analog_range_pkg::IN_TEMP) ##0 (samples_in[g].value > 18'sd10000)
            |=> in_res_q[g].word == 16'h7fff;
        endproperty
        a_temp_sat: assert property (p_temp_sat) else $error("temperature overflow not saturated");

        property p_out_bip_zero;
            @(posedge clk_in) disable iff (reset_in)
            out_reqs_in[g].valid && out_reqs_in[g].mode == analog_range_pkg::OUT_BIPOLAR
            && ($signed(out_reqs_in[g].word) > 16'sd32511 || $signed(out_reqs_in[g].word) < -16'sd32512)
            |=> out_res_q[g].level == 17'sd0;
        endproperty
        a_out_bip_zero: assert property (p_out_bip_zero) else $error("bipolar output not zero");

        property p_out_loop_span;
            @(posedge clk_in) disable iff (reset_in)
            out_reqs_in[g].valid && out_reqs_in[g].mode == analog_range_pkg::OUT_LOOP
            |=> out_res_q[g].level == (($signed($past(out_reqs_in[g].word)) < -16'sd6912
                || $signed($past(out_reqs_in[g].word)) > 16'sd32511) ? 17'sd0
                : $signed($past(out_reqs_in[g].word) & 16'hfff0) + 17'sd6912);
        endproperty
        a_out_loop_span: assert property (p_out_loop_span) else $error("loop output level wrong");

        property p_class_timing;
            @(posedge clk_in) disable iff (reset_in)
            samples_in[g].valid && !wire_d[g] |=> in_res_q[g].valid && in_res_q[g].cls == $past(in_cls);
        endproperty
        a_class_timing: assert property (p_class_timing) else $error("range class late");
    end

    always_comb begin
        diag_d = '0;
        diag_d[analog_range_pkg::DIAG_WIRE_BIT]  = |wire_d;
        diag_d[analog_range_pkg::DIAG_UFLOW_BIT] = |uflow_d;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            in_res_q  <= '0;
            out_res_q <= '0;
            wire_q    <= '0;
            uflow_q   <= '0;
            diag_q    <= '0;
        end else begin
            in_res_q  <= in_res_d;
            out_res_q <= out_res_d;
            wire_q    <= wire_d;
            uflow_q   <= uflow_d;
            diag_q    <= diag_d;
        end
    end

    assign in_results_out  = in_res_q;
    assign out_results_out = out_res_q;
    assign diag_out        = diag_q;
endmodule : analog_value_range_encoder

`default_nettype wire

// file: range_classify.sv
// Shared constants and types for the analog value range encoder, plus the range classifier.
// Assumes one 100 MHz clock domain; samples arrive already digitized in process-word units.
`timescale 1ns/10ps
`default_nettype none

package analog_range_pkg;
    typedef logic signed [17:0] units_t;
    typedef logic signed [16:0] dac_t;

    localparam logic [15:0] CODE_OVERFLOW  = 16'h7fff;
    localparam logic [15:0] CODE_UNDERFLOW = 16'h8000;
    localparam units_t      NOMINAL_HI     = 18'sd27648;
    localparam units_t      NOMINAL_LO     = -18'sd27648;
    localparam units_t      OVER_HI        = 18'sd32511;
    localparam units_t      UNDER_LO_BIP   = -18'sd32512;
    localparam units_t      LOOP_ZERO      = 18'sd0;
    localparam units_t      UNDER_LO_LOOP  = -18'sd4864;
    localparam units_t      UNDER_LO_OUT   = -18'sd6912;
    localparam units_t      TEMP_RATED_HI  = 18'sd8500;
    localparam units_t      TEMP_RATED_LO  = -18'sd2000;
    localparam units_t      TEMP_OVER_HI   = 18'sd10000;
    localparam units_t      TEMP_UNDER_LO  = -18'sd2430;
    // Loop current thresholds in units: 1728 units per mA, 4 mA at zero, rounded so "at or below" holds.
    localparam units_t      LOOP_LOW_1MA1  = -18'sd5012;
    localparam units_t      LOOP_LOW_3MA6  = -18'sd692;
    localparam dac_t        OUT_LOOP_OFFS  = 17'sd6912;
    localparam logic [15:0] IN_JUST_MASK   = 16'hfff8;
    localparam logic [15:0] OUT_JUST_MASK  = 16'hfff0;
    localparam int          DIAG_WIRE_BIT  = 4;
    localparam int          DIAG_UFLOW_BIT = 6;

    typedef enum logic [1:0] {IN_BIPOLAR, IN_LOOP, IN_TEMP} in_mode_t;
    typedef enum logic {OUT_BIPOLAR, OUT_LOOP} out_mode_t;
    typedef enum logic [2:0] {CLS_RATED, CLS_OVER, CLS_UNDER, CLS_OVERFLOW, CLS_UNDERFLOW} cls_t;

    typedef struct packed {
        units_t rated_hi;
        units_t rated_lo;
        units_t over_hi;
        units_t under_lo;
    } limits_t;

    typedef struct packed {
        logic     valid;
        in_mode_t mode;
        logic     wire_check;
        units_t   value;
    } in_sample_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
        cls_t        cls;
    } in_result_t;

    typedef struct packed {
        logic        valid;
        out_mode_t   mode;
        logic [15:0] word;
    } out_req_t;

    typedef struct packed {
        logic valid;
        dac_t level;
        cls_t cls;
    } out_result_t;
endpackage : analog_range_pkg

// Sorts one value into the five ranges; purely combinational.
module range_classifier (
    // Value and the limits of its range
    input  wire analog_range_pkg::units_t  value_in,
    input  wire analog_range_pkg::limits_t limits_in,
    // Range class
    output analog_range_pkg::cls_t         cls_out
);
    always_comb begin
        if (value_in > limits_in.over_hi) begin
            cls_out = analog_range_pkg::CLS_OVERFLOW;
        end else if (value_in < limits_in.under_lo) begin
            cls_out = analog_range_pkg::CLS_UNDERFLOW;
        end else if (value_in > limits_in.rated_hi) begin
            cls_out = analog_range_pkg::CLS_OVER;
        end else if (value_in < limits_in.rated_lo) begin
            cls_out = analog_range_pkg::CLS_UNDER;
        end else begin
            cls_out = analog_range_pkg::CLS_RATED;
        end
    end
endmodule : range_classifier

`default_nettype wire

// file: remote_master.sv
// Behavioural model of the remote bus master that writes output process words.
// Assumes its tasks are called just after a falling edge of the block's clock.
`timescale 1ns/10ps
`default_nettype none

module remote_master #(
    parameter int N = 2
) (
    // Requests to the output channels
    output var analog_range_pkg::out_req_t [N-1:0] out_reqs_out
);
    initial out_reqs_out = '0;

    // Writes one 16-bit two's-complement code to every channel.
    task automatic write_code(input analog_range_pkg::out_mode_t mode, input logic [15:0] code);
        for (int g = 0; g < N; g++) begin
            out_reqs_out[g] = '{valid: 1'b1, mode: mode, word: code};
        end
    endtask : write_code

    // Released words are inverted, so a stale code is never mistaken for a held one.
    task automatic release_bus();
        for (int g = 0; g < N; g++) begin
            out_reqs_out[g].valid = 1'b0;
            out_reqs_out[g].word  = ~out_reqs_out[g].word;
        end
    endtask : release_bus
endmodule : remote_master
`default_nettype wire

// file: testbench.sv
// Self-checking testbench for the analog value range encoder with two channels.
// Assumes the remote master model drives the output requests; inputs change at falling edges.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int N = 2;
    logic                                  clk_in;
    logic                                  reset_in;
    analog_range_pkg::in_sample_t [N-1:0]  samples_in;
    analog_range_pkg::in_result_t [N-1:0]  in_results_out;
    analog_range_pkg::out_req_t [N-1:0]    out_reqs;
    analog_range_pkg::out_result_t [N-1:0] out_results_out;
    logic [7:0]                            diag_out;
    int                                    bad_count;
    int                                    checked;
    int                                    cycles;

    analog_value_range_encoder #(.CHANNELS(N)) analog_value_range_encoder_inst (
        .clk_in(clk_in), .reset_in(reset_in), .samples_in(samples_in), .in_results_out(in_results_out),
        .out_reqs_in(out_reqs), .out_results_out(out_results_out), .diag_out(diag_out));
    remote_master #(.N(N)) remote_master_inst (.out_reqs_out(out_reqs));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [18:0] exp_in(analog_range_pkg::in_mode_t m, logic wc, int v);
        int hi;
        int lo;
        int rh;
        int rl;
        logic [15:0] w;
        analog_range_pkg::cls_t c;
        hi = (m == analog_range_pkg::IN_TEMP) ? 10000 : 32511;
        lo = (m == analog_range_pkg::IN_TEMP) ? -2430 : (m == analog_range_pkg::IN_LOOP) ? -4864 : -32512;
        rh = (m == analog_range_pkg::IN_TEMP) ? 8500 : 27648;
        rl = (m == analog_range_pkg::IN_TEMP) ? -2000 : (m == analog_range_pkg::IN_LOOP) ? 0 : -27648;
        w = (m == analog_range_pkg::IN_TEMP) ? 16'(v) : 16'(v) & 16'hfff8;
        c = (v > rh) ? analog_range_pkg::CLS_OVER : (v < rl) ? analog_range_pkg::CLS_UNDER
            : analog_range_pkg::CLS_RATED;
        if (v > hi) begin
            w = 16'h7fff;
            c = analog_range_pkg::CLS_OVERFLOW;
        end
        if (v < lo || (m == analog_range_pkg::IN_LOOP && wc && v <= -692)) begin
            w = 16'h8000;
            c = analog_range_pkg::CLS_UNDERFLOW;
        end
        return {w, c};
    endfunction : exp_in

    function automatic logic [19:0] exp_out(analog_range_pkg::out_mode_t m, int v);
        logic loop;
        analog_range_pkg::cls_t c;
        loop = (m == analog_range_pkg::OUT_LOOP);
        c = (v > 27648) ? analog_range_pkg::CLS_OVER : (v < (loop ? 0 : -27648)) ? analog_range_pkg::CLS_UNDER
            : analog_range_pkg::CLS_RATED;
        if (v > 32511) return {17'h0, analog_range_pkg::CLS_OVERFLOW};
        if (v < (loop ? -6912 : -32512)) return {17'h0, analog_range_pkg::CLS_UNDERFLOW};
        return {17'((v & ~15) + (loop ? 6912 : 0)), c};
    endfunction : exp_out

    // Drives the samples back to back on both channels, then idles one cycle to see the word hold.
    task automatic run_in(input analog_range_pkg::in_mode_t m, input logic wc, input int vals[$]);
        logic [7:0]  d;
        logic [18:0] e;
        foreach (vals[i]) begin
            for (int g = 0; g < N; g++) samples_in[g] = '{1'b1, m, wc, 18'(vals[i])};
            e = exp_in(m, wc, vals[i]);
            d = 8'h00;
            d[4] = (m == analog_range_pkg::IN_LOOP) && wc && vals[i] <= -692;
            d[6] = (m == analog_range_pkg::IN_LOOP) && !wc && vals[i] <= -5012;
            @(negedge clk_in);
            for (int g = 0; g < N; g++) begin
                check("in_valid", 20'(in_results_out[g].valid), 20'h1);
                check("in_word", 20'(in_results_out[g].word), 20'(e[18:3]));
                check("in_cls", 20'(in_results_out[g].cls), 20'(e[2:0]));
            end
            check("diag", 20'(diag_out), 20'(d));
        end
        samples_in = '0;
        @(negedge clk_in);
        check("in_hold", 20'({in_results_out[0].valid, in_results_out[0].word, in_results_out[0].cls}),
              20'(exp_in(m, wc, vals[$])));
    endtask : run_in

    // Writes codes through the master; a slow master leaves an idle cycle between writes.
    task automatic run_out(input analog_range_pkg::out_mode_t m, input bit slow, input int vals[$]);
        foreach (vals[i]) begin
            remote_master_inst.write_code(m, 16'(vals[i]));
            @(negedge clk_in);
            check("out_valid", 20'(out_results_out[1].valid), 20'h1);
            check("out_level", out_results_out[1][19:0], exp_out(m, vals[i]));
            if (slow) begin
                remote_master_inst.release_bus();
                @(negedge clk_in);
                check("out_hold", {out_results_out[0].level, out_results_out[0].cls}, exp_out(m, vals[i]));
            end
        end
        remote_master_inst.release_bus();
        @(negedge clk_in);
    endtask : run_out

    task automatic scen_in_bipolar();
        run_in(analog_range_pkg::IN_BIPOLAR, 1'b0,
               {0, 27648, 27649, 32511, 32512, -27648, -27649, -32512, -32513, 5});
    endtask : scen_in_bipolar

    task automatic scen_in_loop();
        run_in(analog_range_pkg::IN_LOOP, 1'b0,
               {0, 27648, 27649, 32511, 40000, -1, -4864, -4865, -5012, -5011, -6000});
    endtask : scen_in_loop

    task automatic scen_in_wire();
        run_in(analog_range_pkg::IN_LOOP, 1'b1, {-691, -692, 100, -700});
    endtask : scen_in_wire

    task automatic scen_in_temp();
        run_in(analog_range_pkg::IN_TEMP, 1'b0, {8500, 8501, 10000, 10001, -2000, -2001, -2430, -2431, 7});
    endtask : scen_in_temp

    task automatic scen_out_bipolar();
        run_out(analog_range_pkg::OUT_BIPOLAR, 1'b0,
                {32511, 32512, 32767, 27648, 27649, -27648, -27649, -32512, -32513, -32768, 21});
    endtask : scen_out_bipolar

    task automatic scen_out_loop();
        run_out(analog_range_pkg::OUT_LOOP, 1'b1, {0, 27648, 27649, 32511, 32512, -1, -6912, -6913, -20000});
    endtask : scen_out_loop

    // Resets the block (mid-run with the wire flag set on its second call), then checks every output is cleared.
    task automatic scen_reset();
        reset_in = 1'b1;
        @(negedge clk_in);
        check("reset_state", 20'(|{in_results_out, out_results_out, diag_out}), 20'h0);
        reset_in = 1'b0;
    endtask : scen_reset

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        reset_in   = 1'b1;
        samples_in = '0;
        bad_count  = 0;
        checked    = 0;
        cycles     = 0;
        repeat (8) @(negedge clk_in);
        scen_reset();
        scen_in_bipolar();
        scen_in_loop();
        scen_in_wire();
        scen_reset();
        scen_in_temp();
        scen_out_bipolar();
        scen_out_loop();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
